// >>> rtws_dev.sv
`timescale 1ns/100ps
module rtws_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = rtws_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             srst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  // Only power-of-two depths of two or more are served.
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("rtws_fifo: DEPTH must be a power of two, WIDTH positive");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  wire              full  = (wr_reg[AW] != rd_reg[AW]) &&
                            (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire              empty = (wr_reg == rd_reg);
  wire              push  = in_valid & ~full;
  wire              pop   = out_ready & ~empty;

  // Handshakes and head of queue.
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[rd_reg[AW-1:0]];

  // Storage array takes pushed words.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  // Pointers carry one extra wrap bit to tell full from empty.
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_reg + (AW+1)'(push);
      rd_reg <= rd_reg + (AW+1)'(pop);
    end
  end
endmodule // rtws_fifo

module rtws_dev #(
  parameter int NUM_REGS = rtws_pkg::NUM_REGS
) (
  // Clock and reset.
  input  wire logic       CLK,
  input  wire logic       SRST,
  // Two-wire bus.
  rtws_if.dev             BUS,
  // Register access port.
  output logic [7:0]      REG_ADDR,
  output logic            REG_WR,
  output logic [7:0]      REG_WDATA,
  output logic            REG_RD,
  input  wire logic [7:0] REG_RDATA,
  // Status.
  output logic            BUSY
);
  // The pointer is eight bits wide, so at most 256 registers.
  if (NUM_REGS < 1 || NUM_REGS > 256) begin : g_bad
    $error("rtws_dev: NUM_REGS must be 1 to 256");
  end

  typedef enum logic [2:0] {
    D_IDLE, D_RX, D_RX_ACK, D_TX, D_TX_ACK
  } rtws_dev_state_t;
  typedef enum logic [1:0] {K_ADDR, K_WORD, K_DATA} rtws_kind_t;

  localparam logic [7:0] PTR_LAST = 8'(NUM_REGS - 1);

  // Next pointer value, wrapping after the last register.
  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    ptr_inc = (p >= PTR_LAST) ? rtws_pkg::PTR_RESET : p + 8'h01; // RULE23
  endfunction

  rtws_dev_state_t state_reg, state_next;
  rtws_kind_t      kind_reg, kind_next;
  logic [3:0]      bits_reg, bits_next;
  logic [7:0]      shift_reg, shift_next;
  logic [7:0]      ptr_reg, ptr_next;
  logic            rw_reg, rw_next;
  logic            ackd_reg, ackd_next;
  logic            low_reg, low_next;
  logic            wr_reg, wr_next;
  logic [7:0]      wdata_reg, wdata_next;
  logic            rd_go;
  logic            scl_meta, scl_sync, scl_prev;
  logic            sda_meta, sda_sync, sda_prev;

  // Both lines come from another domain: two stages, then a history
  // stage for edge detection.
  always_ff @(posedge CLK) begin
    scl_meta <= BUS.scl;
    scl_sync <= scl_meta;
    scl_prev <= scl_sync;
    sda_meta <= BUS.sda;
    sda_sync <= sda_meta;
    sda_prev <= sda_sync;
  end

  // Line events; oversampling at 125 MHz serves both bus rates.
  wire scl_rise  = scl_sync & ~scl_prev; // RULE21
  wire scl_fall  = ~scl_sync & scl_prev;
  wire start_det = scl_sync & scl_prev & sda_prev & ~sda_sync; // RULE2
  wire stop_det  = scl_sync & scl_prev & ~sda_prev & sda_sync; // RULE3
  wire addr_hit  = (shift_reg[7:1] == rtws_pkg::DEV_ADDR); // RULE12
  wire byte_done = scl_fall && (bits_reg == rtws_pkg::BIT_ACK); // RULE6

  // Outputs; the data line is only ever pulled low.
  assign BUS.sda_d_val = 1'h0;
  assign BUS.sda_d_en  = low_reg;
  assign REG_ADDR      = ptr_reg;
  assign REG_WR        = wr_reg;
  assign REG_WDATA     = wdata_reg;
  assign REG_RD        = rd_go;
  assign BUSY          = (state_reg != D_IDLE);

  // Protocol engine; data line changes only after a clock fall.
  always_comb begin
    state_next = state_reg;
    kind_next  = kind_reg;
    bits_next  = bits_reg;
    shift_next = shift_reg;
    ptr_next   = ptr_reg;
    rw_next    = rw_reg;
    ackd_next  = ackd_reg;
    low_next   = low_reg;
    wdata_next = wdata_reg;
    wr_next    = 1'h0;
    rd_go      = 1'h0;
    // Pointer advances the cycle after a write strobe.
    if (wr_reg) begin
      ptr_next = ptr_inc(ptr_reg); // RULE15
    end
    if (start_det) begin
      state_next = D_RX; // RULE11
      kind_next  = K_ADDR;
      bits_next  = 4'h0;
      low_next   = 1'h0;
    end else if (stop_det) begin
      state_next = D_IDLE; // RULE3
      low_next   = 1'h0;
    end else begin
      unique case (state_reg)
        D_IDLE: begin
          low_next = 1'h0; // RULE22
        end
        D_RX: begin
          if (scl_rise && bits_reg != rtws_pkg::BIT_ACK) begin
            shift_next = {shift_reg[6:0], sda_sync}; // RULE5
            bits_next  = bits_reg + 4'h1;
          end
          if (byte_done) begin
            state_next = D_RX_ACK;
            low_next   = 1'h1; // RULE8 RULE13
            unique case (kind_reg)
              K_ADDR: begin
                rw_next = shift_reg[0];
                if (!addr_hit) begin
                  state_next = D_IDLE; // RULE22
                  low_next   = 1'h0;
                end
              end
              K_WORD: begin
                ptr_next = shift_reg; // RULE14
              end
              K_DATA: begin
                wr_next    = 1'h1; // RULE15
                wdata_next = shift_reg;
              end
            endcase
          end
        end
        D_RX_ACK: begin
          // Acknowledge held low until the ninth clock falls.
          if (scl_fall) begin
            bits_next = 4'h0;
            if (kind_reg == K_ADDR && rw_reg == rtws_pkg::RW_READ) begin
              rd_go      = 1'h1; // RULE18
              shift_next = REG_RDATA; // RULE17
              ptr_next   = ptr_inc(ptr_reg);
              low_next   = ~REG_RDATA[7]; // RULE4
              state_next = D_TX;
            end else begin
              low_next   = 1'h0;
              kind_next  = (kind_reg == K_ADDR) ? K_WORD : K_DATA; // RULE10
              state_next = D_RX;
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (bits_reg == rtws_pkg::BIT_LAST) begin
              low_next   = 1'h0;
              state_next = D_TX_ACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'h0};
              low_next   = ~shift_reg[6]; // RULE4
              bits_next  = bits_reg + 4'h1;
            end
          end
        end
        D_TX_ACK: begin
          if (scl_rise) begin
            ackd_next = ~sda_sync;
          end
          if (scl_fall) begin
            bits_next = 4'h0;
            if (ackd_reg) begin
              rd_go      = 1'h1; // RULE17
              shift_next = REG_RDATA;
              ptr_next   = ptr_inc(ptr_reg);
              low_next   = ~REG_RDATA[7];
              state_next = D_TX;
            end else begin
              low_next   = 1'h0; // RULE9
              state_next = D_IDLE; // RULE20
            end
          end
        end
      endcase
    end
  end

  // State registers; the pointer keeps its value between transfers.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_reg <= D_IDLE;
      kind_reg  <= K_ADDR;
      bits_reg  <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg   <= rtws_pkg::PTR_RESET;
      rw_reg    <= rtws_pkg::RW_WRITE;
      ackd_reg  <= 1'h0;
      low_reg   <= 1'h0;
      wr_reg    <= 1'h0;
      wdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      kind_reg  <= kind_next;
      bits_reg  <= bits_next;
      shift_reg <= shift_next;
      ptr_reg   <= ptr_next;
      rw_reg    <= rw_next;
      ackd_reg  <= ackd_next;
      low_reg   <= low_next;
      wr_reg    <= wr_next;
      wdata_reg <= wdata_next;
    end
  end
endmodule // rtws_dev

// >>> rtws_pkg.sv
// Notes on behaviour
// RULE1 - Master starts only while both lines idle high.
// RULE2 - Data falling while clock high is start.
// RULE3 - Data rising while clock high is stop.
// RULE4 - Data changes only while clock is low.
// RULE5 - One clock pulse per bit, sampled high.
// RULE6 - Eight-bit bytes, ninth bit acknowledge by receiver.
// RULE7 - Master makes every clock, including acknowledge pulse.
// RULE8 - Acknowledge holds data low through clock high.
// RULE9 - After final read byte device releases data.
// RULE10 - Any byte count; master decides how many.
// RULE11 - Repeated start restarts address reception.
// RULE12 - Address 1101000 then direction, one means read.
// RULE13 - Matching address is acknowledged either direction.
// RULE14 - Write: second byte loads register pointer.
// RULE15 - Write: store byte, acknowledge, advance pointer.
// RULE16 - Master ends register write with stop.
// RULE17 - Read: send from pointer, advancing per byte.
// RULE18 - Read without address uses last pointer.
// RULE19 - Master acknowledges all but final read byte.
// RULE20 - Device sends until a not-acknowledge arrives.
// RULE21 - Works at 100kHz and 400kHz clock rates.
// RULE22 - Foreign address: no acknowledge, line released.
// RULE23 - Pointer wraps to zero past last register.
package rtws_pkg;
  // Bus address and direction encodings.
  localparam logic [6:0] DEV_ADDR = 7'h68;
  localparam logic       RW_READ  = 1'h1;
  localparam logic       RW_WRITE = 1'h0;
  // Bit counting within a byte and its acknowledge slot.
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;
  // Register map size and pointer reset value.
  localparam int         NUM_REGS  = 10;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // Timing: system clock and serial clock rates.
  localparam int CLK_KHZ      = 125000;
  localparam int SCL_STD_KHZ  = 100;
  localparam int SCL_FAST_KHZ = 400;
  // Quarter of a serial clock period in system cycles, rounded up.
  localparam int QUARTER_FAST =
    (CLK_KHZ + 4 * SCL_FAST_KHZ - 1) / (4 * SCL_FAST_KHZ);
  localparam int QUARTER_STD =
    (CLK_KHZ + 4 * SCL_STD_KHZ - 1) / (4 * SCL_STD_KHZ);
  // Depth of the read data buffer in the master.
  localparam int FIFO_DEPTH = 16;
  // Kind of byte the master is moving.
  typedef enum logic [2:0] {
    ST_ADDR_W, ST_WORD, ST_WDATA, ST_ADDR_R, ST_RDATA
  } rtws_stage_t;
endpackage

// >>> rtws_if.sv
`timescale 1ns/100ps
interface rtws_if;
  // Master drives clock and data, device drives data only.
  logic scl_h_val;
  logic scl_h_en;
  logic sda_h_val;
  logic sda_h_en;
  logic sda_d_val;
  logic sda_d_en;
  logic scl;
  logic sda;

  // Open-drain wired-AND with pull-ups on both lines.
  assign scl = ~(scl_h_en & ~scl_h_val);
  assign sda = ~((sda_h_en & ~sda_h_val) | (sda_d_en & ~sda_d_val));

  modport dev (input scl, input sda, output sda_d_val, output sda_d_en);
  modport host (input scl, input sda, output scl_h_val, output scl_h_en,
                output sda_h_val, output sda_h_en);
endinterface

// >>> rtws_host.sv
`timescale 1ns/100ps
module rtws_host #(
  parameter int QUARTER = rtws_pkg::QUARTER_FAST,
  parameter int DEPTH   = rtws_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic       CLK,
  input  wire logic       SRST,
  // Two-wire bus.
  rtws_if.host            BUS,
  // Command.
  input  wire logic       CMD_VALID,
  output logic            CMD_READY,
  input  wire logic       CMD_READ,
  input  wire logic       CMD_SET_PTR,
  input  wire logic [7:0] CMD_PTR,
  input  wire logic [7:0] CMD_LEN,
  // Write data stream.
  input  wire logic       WR_VALID,
  output logic            WR_READY,
  input  wire logic [7:0] WR_DATA,
  // Read data stream.
  output logic            RD_VALID,
  input  wire logic       RD_READY,
  output logic [7:0]      RD_DATA,
  // Completion.
  output logic            DONE,
  output logic            NACK
);
  // The device needs a few cycles to see each clock edge.
  if (QUARTER < 8 || QUARTER > 4095) begin : g_bad
    $error("rtws_host: QUARTER must be 8 to 4095");
  end

  typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} rtws_host_t;

  rtws_host_t          state_reg, state_next;
  rtws_pkg::rtws_stage_t stage_reg, stage_next;
  logic [11:0] div_reg;
  logic [1:0]  q_reg, q_next;
  logic [3:0]  bit_reg, bit_next;
  logic [7:0]  shift_reg, shift_next, cnt_reg, cnt_next, ptr_reg, ptr_next;
  logic        read_reg, read_next;
  logic        sdal_reg, sdal_next, scll_reg, scll_next;
  logic        ackd_reg, ackd_next, err_reg, err_next;
  logic        done_reg, done_next, nack_reg, nack_next;
  logic        sda_meta, sda_sync, push, fifo_ready, take_wr;
  logic [7:0]  next_byte;

  // Bus data comes from outside: two stages before use.
  always_ff @(posedge CLK) begin
    sda_meta <= BUS.sda;
    sda_sync <= sda_meta;
  end

  // Quarter-period enable divider, idle while no command runs.
  wire tick  = (div_reg == 12'(QUARTER - 1)); // RULE21
  wire first = (q_reg == 2'h0) && (bit_reg == 4'h0);
  wire stall = (state_reg == H_BYTE) && first &&
    ((stage_reg == rtws_pkg::ST_WDATA && !WR_VALID) ||
     (stage_reg == rtws_pkg::ST_RDATA && !fifo_ready));
  wire adv   = tick && !stall;
  wire rx    = (stage_reg == rtws_pkg::ST_RDATA);
  wire dbit  = (bit_reg == 4'h0) ? next_byte[7] : shift_reg[7];
  wire tx_ok = ackd_reg | rx;

  // Byte to send for each stage.
  assign next_byte =
    (stage_reg == rtws_pkg::ST_ADDR_W) ?
      {rtws_pkg::DEV_ADDR, rtws_pkg::RW_WRITE} : // RULE12
    (stage_reg == rtws_pkg::ST_ADDR_R) ?
      {rtws_pkg::DEV_ADDR, rtws_pkg::RW_READ} :
    (stage_reg == rtws_pkg::ST_WORD) ? ptr_reg : WR_DATA;
  assign take_wr   = adv && (state_reg == H_BYTE) && first &&
                     (stage_reg == rtws_pkg::ST_WDATA);
  assign push      = adv && (state_reg == H_BYTE) && rx &&
                     (q_reg == 2'h0) && (bit_reg == rtws_pkg::BIT_ACK);
  assign CMD_READY = (state_reg == H_IDLE);
  assign WR_READY  = take_wr;
  assign DONE      = done_reg;
  assign NACK      = nack_reg;
  assign BUS.scl_h_val = 1'h0;
  assign BUS.scl_h_en  = scll_reg; // RULE7
  assign BUS.sda_h_val = 1'h0;
  assign BUS.sda_h_en  = sdal_reg;

  // Read data buffer; a full buffer holds the clock low.
  rtws_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .clk(CLK), .srst(SRST), .in_valid(push), .in_ready(fifo_ready),
    .in_data(shift_reg), .out_valid(RD_VALID), .out_ready(RD_READY),
    .out_data(RD_DATA));

  // Bit sequencer: quarter 0 sets data, 1 raises clock, 2 samples,
  // 3 lowers clock.
  always_comb begin
    state_next = state_reg; stage_next = stage_reg; q_next = q_reg;
    bit_next = bit_reg; shift_next = shift_reg; cnt_next = cnt_reg;
    ptr_next = ptr_reg; read_next = read_reg;
    sdal_next = sdal_reg; scll_next = scll_reg; ackd_next = ackd_reg;
    err_next = err_reg; done_next = 1'h0; nack_next = nack_reg;
    if (state_reg == H_IDLE) begin
      if (CMD_VALID) begin
        read_next = CMD_READ;
        ptr_next = CMD_PTR; cnt_next = CMD_LEN; err_next = 1'h0;
        stage_next = (CMD_READ && !CMD_SET_PTR) ?
          rtws_pkg::ST_ADDR_R : rtws_pkg::ST_ADDR_W; // RULE18
        state_next = H_START; q_next = 2'h0; // RULE1
      end
    end else if (adv) begin
      q_next = q_reg + 2'h1;
      unique case (state_reg)
        H_START: unique case (q_reg)
          2'h0: sdal_next = 1'h0;
          2'h1: scll_next = 1'h0;
          2'h2: sdal_next = 1'h1; // RULE2
          2'h3: begin
            scll_next = 1'h1; state_next = H_BYTE; bit_next = 4'h0;
          end
        endcase
        H_BYTE: unique case (q_reg)
          2'h0: begin
            if (bit_reg == 4'h0) shift_next = next_byte;
            if (bit_reg == rtws_pkg::BIT_ACK)
              sdal_next = rx && (cnt_reg > 8'h01); // RULE19
            else
              sdal_next = !rx && !dbit; // RULE4
          end
          2'h1: scll_next = 1'h0; // RULE5
          2'h2: begin
            if (bit_reg == rtws_pkg::BIT_ACK) ackd_next = ~sda_sync;
            else shift_next = {shift_reg[6:0], sda_sync};
          end
          2'h3: begin
            scll_next = 1'h1;
            bit_next = bit_reg + 4'h1;
            if (bit_reg == rtws_pkg::BIT_ACK) begin // RULE6
              bit_next = 4'h0;
              if (!tx_ok) begin
                err_next = 1'h1; state_next = H_STOP;
              end else unique case (stage_reg)
                rtws_pkg::ST_ADDR_W: stage_next = rtws_pkg::ST_WORD;
                rtws_pkg::ST_ADDR_R: stage_next = rtws_pkg::ST_RDATA;
                rtws_pkg::ST_WORD: begin
                  stage_next = read_reg ? rtws_pkg::ST_ADDR_R :
                                          rtws_pkg::ST_WDATA;
                  if (read_reg) state_next = H_START; // RULE11
                  else if (cnt_reg == 8'h00) state_next = H_STOP;
                end
                default: begin
                  cnt_next = cnt_reg - 8'h01; // RULE10
                  if (cnt_reg <= 8'h01) state_next = H_STOP; // RULE16
                end
              endcase
            end
          end
        endcase
        H_STOP: unique case (q_reg)
          2'h0: sdal_next = 1'h1;
          2'h1: scll_next = 1'h0;
          2'h2: sdal_next = 1'h0; // RULE3
          2'h3: begin
            state_next = H_IDLE; done_next = 1'h1; nack_next = err_reg;
          end
        endcase
        default: state_next = H_IDLE;
      endcase
    end
  end

  // Registers; the bus is released during reset.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_reg <= H_IDLE; stage_reg <= rtws_pkg::ST_ADDR_W;
      div_reg <= 12'h000; q_reg <= 2'h0; bit_reg <= 4'h0;
      shift_reg <= 8'h00; cnt_reg <= 8'h00; ptr_reg <= 8'h00;
      read_reg <= 1'h0; sdal_reg <= 1'h0;
      scll_reg <= 1'h0; ackd_reg <= 1'h0; err_reg <= 1'h0;
      done_reg <= 1'h0; nack_reg <= 1'h0;
    end else begin
      div_reg <= (tick || state_reg == H_IDLE) ? 12'h000 : div_reg + 12'h001;
      state_reg <= state_next; stage_reg <= stage_next; q_reg <= q_next;
      bit_reg <= bit_next; shift_reg <= shift_next; cnt_reg <= cnt_next;
      ptr_reg <= ptr_next; read_reg <= read_next;
      sdal_reg <= sdal_next; scll_reg <= scll_next; ackd_reg <= ackd_next;
      err_reg <= err_next; done_reg <= done_next; nack_reg <= nack_next;
    end
  end
endmodule // rtws_host

// >>> rtws_monitor.sv
`timescale 1ns/100ps
module rtws_monitor (
  // Clock and reset.
  input wire logic CLK,
  input wire logic SRST,
  // Drive enables, values and resolved levels of the bus.
  input wire logic scl_h_val,
  input wire logic scl_h_en,
  input wire logic sda_h_val,
  input wire logic sda_h_en,
  input wire logic sda_d_val,
  input wire logic sda_d_en,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q_reg, sda_q_reg, first_reg, rw_reg, match_reg, nack_reg;
  logic [3:0] cnt_reg;
  logic [6:0] sh_reg;
  // Line events, the ninth clock of a byte and the direction bit clock.
  wire start_w = scl & scl_q_reg & sda_q_reg & ~sda;
  wire stop_w  = scl & scl_q_reg & ~sda_q_reg & sda;
  wire rise_w  = scl & ~scl_q_reg;
  wire ack_w   = rise_w & (cnt_reg == 4'h8);
  wire addr_w  = rise_w & first_reg & (cnt_reg == 4'h7);
  // Clock count within a byte, framed by start and stop.
  always_ff @(posedge CLK) begin
    scl_q_reg <= scl;
    sda_q_reg <= sda;
    if (SRST || start_w || stop_w) begin
      cnt_reg   <= 4'h0;
      first_reg <= start_w & ~SRST;
      nack_reg  <= 1'b0;
    end else if (rise_w) begin
      cnt_reg   <= ack_w ? 4'h0 : cnt_reg + 4'h1;
      first_reg <= first_reg & ~ack_w;
      nack_reg  <= nack_reg | (ack_w & ~first_reg & rw_reg & match_reg & sda);
    end
  end
  // Address and direction of the current transfer.
  always_ff @(posedge CLK) begin
    if (rise_w & first_reg & (cnt_reg < 4'h7))
      sh_reg <= {sh_reg[5:0], sda};
    if (SRST)
      match_reg <= 1'b0;
    else if (addr_w)
      match_reg <= (sh_reg == rtws_pkg::DEV_ADDR);
    if (addr_w)
      rw_reg <= sda;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // A driven bit holds for 8 cycles after the clock rises; the device is quiet for 8 cycles after stop.
  sequence s_held;
    (sda_d_en & ~sda) [*8];
  endsequence
  sequence s_quiet;
    (~sda_d_en) [*8];
  endsequence
  a_addr_ack_drive: assert property (
    ack_w && first_reg && match_reg |-> sda_d_en)
    else $error("address byte not acknowledged");
  a_write_byte_ack: assert property (
    ack_w && !first_reg && match_reg && !rw_reg |-> sda_d_en)
    else $error("written byte not acknowledged");
  a_host_frees_ack: assert property (
    ack_w && match_reg && (first_reg || !rw_reg) |-> !sda_h_en)
    else $error("host drives data in the device ack slot");
  a_read_host_free: assert property (
    rise_w && !ack_w && !first_reg && match_reg && rw_reg && !nack_reg
    |-> !sda_h_en) else $error("host drives data during a read bit");
  a_drive_held_high: assert property (
    rise_w && sda_d_en |-> s_held)
    else $error("device drive dropped while clock high");
  a_change_clock_low: assert property (
    $changed(sda_d_en) |-> !scl)
    else $error("device data changed while clock high");
  a_nack_release: assert property (
    nack_reg && scl |-> !sda_d_en)
    else $error("device drives data after a not-acknowledge");
  a_stop_quiet: assert property (
    stop_w |=> s_quiet) else $error("device drives data after stop");
  // Every driver only ever pulls its line low, never pushes it high.
  a_drive_pulls_low: assert property (
    !(scl_h_en && scl_h_val) && !(sda_h_en && sda_h_val) &&
    !(sda_d_en && sda_d_val)) else $error("a driver pushes a line high");
endmodule // rtws_monitor

// >>> tb_rtws_two_wire_slave_port.sv
`timescale 1ns/100ps
`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("[FAIL] %0t got %h expected %h", $time, (g), (e)); \
  end \
end
module tb_rtws_two_wire_slave_port;
  logic        CLK = 1'b0;
  logic        SRST = 1'b1;
  logic        cmd_valid, cmd_read, cmd_set_ptr, wr_valid, rd_ready, cmd_ready;
  logic        wr_ready, rd_valid, done, nack, reg_wr, reg_rd, busy;
  logic [7:0]  cmd_ptr, cmd_len, wr_data, rd_data, seq, eptr;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [7:0]  reg_mem [0:255];
  logic [7:0]  exp_mem [0:255];
  logic [7:0]  frgn [0:1] = '{8'hD2, 8'h00};
  int          error_cnt = 0;
  int          checked = 0;
  int          rd_seen = 0;
  // Rows of read, set pointer, pointer and length.
  logic [17:0] rows [0:5] = '{18'h10203, 18'h30203, 18'h10700, 18'h20002,
                              18'h10804, 18'h30800};
  rtws_if bus_a ();
  rtws_if bus_b ();
  rtws_host #(.QUARTER(10)) u_rtws_host (
    .CLK(CLK), .SRST(SRST), .BUS(bus_a),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_READ(cmd_read),
    .CMD_SET_PTR(cmd_set_ptr), .CMD_PTR(cmd_ptr), .CMD_LEN(cmd_len),
    .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data),
    .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data),
    .DONE(done), .NACK(nack));
  rtws_dev u_rtws_dev (
    .CLK(CLK), .SRST(SRST), .BUS(bus_a), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .BUSY(busy));
  rtws_dev u_rtws_dev_b (
    .CLK(CLK), .SRST(SRST), .BUS(bus_b), .REG_ADDR(), .REG_WR(),
    .REG_WDATA(), .REG_RD(), .REG_RDATA(8'h00), .BUSY());
  rtws_monitor u_rtws_monitor (
    .CLK(CLK), .SRST(SRST), .scl_h_val(bus_a.scl_h_val),
    .scl_h_en(bus_a.scl_h_en), .sda_h_val(bus_a.sda_h_val),
    .sda_h_en(bus_a.sda_h_en), .sda_d_val(bus_a.sda_d_val),
    .sda_d_en(bus_a.sda_d_en), .scl(bus_a.scl), .sda(bus_a.sda));
  // Clock, register file behind the device and a hang guard.
  initial forever #4 CLK = ~CLK;
  assign reg_rdata = reg_mem[reg_addr];
  always @(posedge CLK) if (reg_wr === 1'b1) reg_mem[reg_addr] <= reg_wdata;
  always @(posedge CLK) if (reg_rd === 1'b1) rd_seen++;
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end
  // Pointer step with wrap past the last register.
  function automatic logic [7:0] nxt(input logic [7:0] p);
    return (p >= rtws_pkg::NUM_REGS - 1) ? 8'h00 : p + 8'h01;
  endfunction
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hands one command over the valid and ready handshake.
  task automatic send(input logic rd, sp, input logic [7:0] p, n);
    @(posedge CLK);
    #1;
    {cmd_read, cmd_set_ptr, cmd_ptr, cmd_len} = {rd, sp, p, n};
    cmd_valid = 1'b1;
    do @(posedge CLK); while (cmd_ready !== 1'b1);
    #1 cmd_valid = 1'b0;
  endtask
  // Runs a command, feeding and draining the streams against the model.
  task automatic run(input logic rd, sp, input logic [7:0] p, n,
                     input int stall);
    int   wi, ri, nrd, base;
    logic fin;
    {wi, ri, fin} = '0;
    nrd = rd ? ((n == 0) ? 1 : n) : 0;
    if (sp) eptr = p;
    base = rd_seen;
    send(rd, sp, p, n);
    for (int c = 0; c < 40000 && !(fin && ri == nrd); c++) begin
      wr_valid = !rd && wi < n;
      wr_data  = 8'hC3 + seq;
      rd_ready = c >= stall;
      @(posedge CLK);
      if (c == stall - 1) `CHK(bus_a.scl, 1'b0)
      if (wr_ready === 1'b1) begin
        exp_mem[eptr] = wr_data;
        eptr = nxt(eptr);
        seq++;
        wi++;
      end
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
        `CHK(rd_data, exp_mem[eptr])
        eptr = nxt(eptr);
        ri++;
      end
      if (done === 1'b1) begin
        fin = 1'b1;
        `CHK(nack, 1'b0)
      end
      #1;
    end
    `CHK(fin, 1'b1)
    `CHK(rd_seen - base, nrd)
  endtask
  // One bench-made clock phase on the second bus: 5 cycles, 80 ns a period.
  // Data moves one cycle after the clock, so never on a clock edge.
  task automatic bb(input logic c, input logic d);
    @(posedge CLK);
    #1 bus_b.scl_h_en = ~c;
    @(posedge CLK);
    #1 bus_b.sda_h_en = ~d;
    repeat (3) @(posedge CLK);
  endtask
  // Main sequence: table rows, then buffer stall, mid-run reset, foreign.
  initial begin
    {cmd_valid, cmd_read, cmd_set_ptr, wr_valid, rd_ready} = 5'h00;
    {cmd_ptr, cmd_len, wr_data, seq} = 32'h0;
    eptr = rtws_pkg::PTR_RESET;
    {bus_b.scl_h_val, bus_b.scl_h_en, bus_b.sda_h_val, bus_b.sda_h_en} = 4'h0;
    for (int i = 0; i < 256; i++) begin
      reg_mem[i] = 8'h5A ^ i[7:0];
      exp_mem[i] = 8'h5A ^ i[7:0];
    end
    repeat (16) @(posedge CLK);
    #1 SRST = 1'b0;
    @(posedge CLK);
    foreach (rows[r]) run(rows[r][17], rows[r][16], rows[r][15:8],
                          rows[r][7:0], 0);
    run(1'b1, 1'b1, 8'h05, 8'h12, 8000);
    send(1'b0, 1'b1, 8'h03, 8'h02);
    repeat (150) @(posedge CLK);
    #1 SRST = 1'b1;
    repeat (16) @(posedge CLK);
    #1 SRST = 1'b0;
    repeat (3) @(posedge CLK);
    `CHK(busy, 1'b0)
    `CHK(cmd_ready, 1'b1)
    `CHK(bus_a.sda & bus_a.scl, 1'b1)
    eptr = rtws_pkg::PTR_RESET;
    run(1'b1, 1'b0, 8'h00, 8'h01, 0);
    bb(1'b1, 1'b1);
    bb(1'b1, 1'b0);
    foreach (frgn[k]) begin
      for (int i = 7; i >= 0; i--) begin
        bb(1'b0, frgn[k][i]);
        bb(1'b1, frgn[k][i]);
      end
      bb(1'b0, 1'b1);
      bb(1'b1, 1'b1);
      `CHK(bus_b.sda, 1'b1)
    end
    bb(1'b0, 1'b0);
    bb(1'b1, 1'b0);
    bb(1'b1, 1'b1);
    conclude();
  end
endmodule // tb_rtws_two_wire_slave_port
